/* File: core/rtc_flags_reg.sv */
// Contract
// R1: watchdog flag sets when countdown reaches zero unreloaded.
// R2: alarm flag sets when unmasked time fields equal alarm fields.
// R3: supply-drop flag sets below threshold; cleared by flags read.
// R4: oscillator-fail flag sets at power up if oscillator idle for 5 ms.
// R5: oscillator-fail flag clears only when host writes 0.
// R6: oscillator-fail flag survives power cycles; not reset here.
// R7: calibration bit 1 drives 512 Hz square wave on interrupt pin.
// R8: calibration bit resets to 0 on power up.
// R9: write-time bit 1 freezes user-visible time registers.
// R10: write-time falling copies user time into counters.
// R11: read bit 1 holds static time image; host clears it.
// R12: flags read clears clear-on-read flags and releases level interrupt; here a read leaves o_int alone, it follows i_int_level.
// R13: alarm field with mask bit 1 is ignored in the match.
// R14: flags bit 3 reads 0, writes ignored.
//
// Purpose: flags/mode register of the rtc on the async memory bus
// Assumes: bus pins synchronised here; one 8-bit data lane
// Notes: osc flag is kept in a backed-up flop outside i_resetn
`include "rtc_flags_defines.svh"
module rtc_flags_reg (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_por_n,
  input wire logic [16:0] i_addr,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  input wire logic i_wdog_expire,
  input wire logic i_supply_low,
  input wire logic i_osc_running,
  input wire logic i_tick,
  input wire logic [31:0] i_user_time,
  input wire logic [31:0] i_alarm_time,
  input wire logic [3:0] i_alarm_mask,
  input wire logic i_int_level,
  output logic o_int,
  output logic o_time_frozen,
  output logic o_time_load,
  output logic o_read_hold,
  output logic [31:0] o_count_time,
  output logic [31:0] o_visible_time
);
  localparam int OSC_CYC = `OSC_START_CYC;
  // two-flop sync of bus, supply, osc and watchdog pins
  // reset to idle pin levels: strobes high, supply ok, osc up, no expiry
  // a one here on supply or watchdog would fake a flag set after reset
  logic [5:0] s1_reg, s2_reg;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_reg <= 6'h3a;
      s2_reg <= 6'h3a;
    end else begin
      s1_reg <= {i_ce_n, i_we_n, i_oe_n, i_supply_low, i_osc_running,
                 i_wdog_expire};
      s2_reg <= s1_reg;
    end
  end
  logic [16:0] a1_reg, a2_reg;
  logic [7:0] d1_reg, d2_reg;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      a1_reg <= 17'h0;
      a2_reg <= 17'h0;
      d1_reg <= 8'h0;
      d2_reg <= 8'h0;
    end else begin
      a1_reg <= i_addr;
      a2_reg <= a1_reg;
      d1_reg <= i_dq;
      d2_reg <= d1_reg;
    end
  end
  logic ce_n, we_n, oe_n, sup_low, osc_run, wd_exp;
  assign {ce_n, we_n, oe_n, sup_low, osc_run, wd_exp} = s2_reg;
  logic sel;
  assign sel = !ce_n && (a2_reg == `RTC_FLAGS_ADDR);

  // bus access: one read or write event per chip-enable/strobe assertion
  rtc_flags_pkg::bus_state_e bus_reg, bus_next;
  logic rd_evt, wr_evt;
  always_comb begin
    bus_next = bus_reg;
    rd_evt = 1'b0;
    wr_evt = 1'b0;
    unique case (bus_reg)
      rtc_flags_pkg::BUS_IDLE: begin
        if (sel && !we_n) begin
          bus_next = rtc_flags_pkg::BUS_WRITE;
        end else if (sel && !oe_n) begin
          bus_next = rtc_flags_pkg::BUS_READ;
        end
      end
      rtc_flags_pkg::BUS_READ: begin
        if (oe_n || ce_n) begin
          bus_next = rtc_flags_pkg::BUS_IDLE;
          rd_evt = 1'b1; // clear happens after data was taken
        end
      end
      rtc_flags_pkg::BUS_WRITE: begin
        if (we_n || ce_n) begin
          bus_next = rtc_flags_pkg::BUS_IDLE;
          wr_evt = 1'b1; // data latched at end of write
        end
      end
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_reg <= rtc_flags_pkg::BUS_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // alarm compare
  rtc_time_if tif ();
  rtc_alarm_cmp u_cmp (
    .t(tif.cmp)
  );
  assign tif.alarm = i_alarm_time;
  assign tif.alarm_mask = i_alarm_mask; // R13

  // event and mode flags
  logic wdf_reg, wdf_next, af_reg, af_next, pf_reg, pf_next;
  logic [2:0] mode_reg, mode_next;
  logic match_d_reg, wd_d_reg;
  logic [7:0] wdata_reg;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdata_reg <= 8'h0;
    end else if (sel && !we_n) begin
      wdata_reg <= d2_reg;
    end
  end
  always_comb begin
    wdf_next = wdf_reg;
    af_next = af_reg;
    pf_next = pf_reg;
    mode_next = mode_reg;
    if (rd_evt) begin // R12
      wdf_next = 1'b0;
      af_next = 1'b0;
      pf_next = 1'b0; // R3
    end
    if (wr_evt) begin
      mode_next = wdata_reg[`FLAG_CAL:`FLAG_READ];
    end
    // set wins over the clear
    if (wd_exp && !wd_d_reg) wdf_next = 1'b1; // R1
    if (tif.match && !match_d_reg) af_next = 1'b1; // R2
    if (sup_low) pf_next = 1'b1; // R3
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdf_reg <= 1'b0;
      af_reg <= 1'b0;
      pf_reg <= 1'b0;
      mode_reg <= `FLAGS_MODE_RESET; // R8
      match_d_reg <= 1'b0;
      wd_d_reg <= 1'b0;
    end else begin
      wdf_reg <= wdf_next;
      af_reg <= af_next;
      pf_reg <= pf_next;
      mode_reg <= mode_next;
      match_d_reg <= tif.match;
      wd_d_reg <= wd_exp;
    end
  end

  // oscillator fail: power-on check, on its own backed-up reset
  // i_resetn does not touch it, so a plain system reset keeps it
  logic oscillator_fail_flag_reg, oscillator_fail_flag_next, chk_done_reg, chk_done_next;
  logic [19:0] osc_cnt_reg, osc_cnt_next;
  always_comb begin
    oscillator_fail_flag_next = oscillator_fail_flag_reg;
    chk_done_next = chk_done_reg;
    osc_cnt_next = osc_cnt_reg;
    if (!chk_done_reg) begin
      if (osc_run) begin
        chk_done_next = 1'b1;
      end else if (osc_cnt_reg == 20'(OSC_CYC - 1)) begin
        chk_done_next = 1'b1;
        oscillator_fail_flag_next = 1'b1; // R4
      end else begin
        osc_cnt_next = osc_cnt_reg + 20'h1;
      end
    end
    if (wr_evt && !wdata_reg[`FLAG_OSC]) oscillator_fail_flag_next = 1'b0; // R5
  end
  always_ff @(posedge i_ref_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      chk_done_reg <= 1'b0;
      osc_cnt_reg <= 20'h0;
    end else begin
      chk_done_reg <= chk_done_next;
      osc_cnt_reg <= osc_cnt_next;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    oscillator_fail_flag_reg <= oscillator_fail_flag_next; // R6
  end

  // timekeeping counter and visible image
  logic [31:0] cnt_reg, cnt_next, vis_reg, vis_next;
  logic w_d_reg;
  assign tif.now = cnt_reg;
  always_comb begin
    cnt_next = cnt_reg;
    vis_next = vis_reg;
    if (i_tick) cnt_next = cnt_reg + 32'h1;
    if (w_d_reg && !mode_reg[`FLAG_WRITE]) begin
      cnt_next = i_user_time; // R10
      vis_next = i_user_time;
    end else if (!mode_reg[`FLAG_WRITE] && !mode_reg[`FLAG_READ]) begin
      vis_next = cnt_reg; // R9 R11
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 32'h0;
      vis_reg <= 32'h0;
      w_d_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      vis_reg <= vis_next;
      w_d_reg <= mode_reg[`FLAG_WRITE];
    end
  end
  assign o_count_time = cnt_reg;
  assign o_visible_time = vis_reg;
  assign o_time_frozen = mode_reg[`FLAG_WRITE];
  assign o_read_hold = mode_reg[`FLAG_READ];
  assign o_time_load = w_d_reg && !mode_reg[`FLAG_WRITE];

  // interrupt pin: square wave in calibration mode
  logic wave;
  rtc_sq_wave u_sq (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_en(mode_reg[`FLAG_CAL]),
    .o_wave(wave)
  );
  assign o_int = mode_reg[`FLAG_CAL] ? wave : i_int_level; // R7

  // read data
  logic [7:0] rdata_reg;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= 8'h0;
    end else begin
      rdata_reg <= {wdf_reg, af_reg, pf_reg, oscillator_fail_flag_reg, 1'b0, mode_reg}; // R14
    end
  end
  assign o_dq = rdata_reg;
  assign o_dq_oe = sel && !oe_n && we_n;

  chk_rsvd_zero: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !o_dq[`FLAG_RSVD]) else $error("reserved bit set"); // R14
  chk_rd_clears: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    rd_evt && !wd_exp && !sup_low && !tif.match |=> !wdf_reg && !pf_reg)
    else $error("read did not clear flags"); // R12
  chk_osc_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    oscillator_fail_flag_reg && !wr_evt |=> oscillator_fail_flag_reg) else $error("osc flag lost"); // R5
  chk_wd_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wd_exp && !wd_d_reg |=> wdf_reg) else $error("watchdog flag missed"); // R1
  chk_alarm_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    tif.match && !match_d_reg |=> af_reg) else $error("alarm missed"); // R2
  chk_pf_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    sup_low |=> pf_reg) else $error("supply flag missed"); // R3
  chk_freeze_hold: assert property (@(posedge i_ref_clk)
    disable iff (!i_resetn) mode_reg[`FLAG_READ] && $past(mode_reg[`FLAG_READ])
    && !o_time_load |-> $stable(vis_reg)) else $error("image moved"); // R11
  chk_load_copy: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_time_load |=> cnt_reg == $past(i_user_time))
    else $error("load not copied"); // R10
  chk_cal_int: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !mode_reg[`FLAG_CAL] |-> o_int == i_int_level)
    else $error("int not normal"); // R7
  chk_osc_set: assert property (@(posedge i_ref_clk) disable iff (!i_por_n)
    !chk_done_reg && !osc_run && osc_cnt_reg == 20'(OSC_CYC - 1)
    |=> oscillator_fail_flag_reg) else $error("osc fail flag missed"); // R4
  chk_drive_sel: assert property (@(posedge i_ref_clk)
    disable iff (!i_resetn) o_dq_oe |-> sel && we_n)
    else $error("data driven while not selected"); // bus drive only on a selected read
  cov_alarm: cover property (@(posedge i_ref_clk) tif.match && !match_d_reg);
  cov_read: cover property (@(posedge i_ref_clk) rd_evt);
  cov_write: cover property (@(posedge i_ref_clk) wr_evt);
  cov_load: cover property (@(posedge i_ref_clk) o_time_load);
endmodule

/* File: core/rtc_flags_defines.svh */
`ifndef RTC_FLAGS_DEFINES_SVH
`define RTC_FLAGS_DEFINES_SVH
// Purpose: offsets, bit positions, reset values and timing counts
// Assumes: 100 MHz i_ref_clk
// Notes: register address is the byte address on the memory bus
`define RTC_FLAGS_ADDR 17'h1fff0
`define FLAG_WATCHDOG 7
`define FLAG_ALARM 6
`define FLAG_SUPPLY 5
`define FLAG_OSC 4
`define FLAG_RSVD 3
`define FLAG_CAL 2
`define FLAG_WRITE 1
`define FLAG_READ 0
`define FLAGS_MODE_RESET 3'h0
`define CLK_HZ 100000000
`define OSC_START_MS 5
`define OSC_START_CYC ((`CLK_HZ / 1000) * `OSC_START_MS)
`define SQ_WAVE_HZ 512
`define SQ_HALF_CYC (`CLK_HZ / (2 * `SQ_WAVE_HZ))
`endif

/* File: core/rtc_flags_pkg.sv */
// Purpose: shared types for the rtc flags block
// Assumes: nothing
// Notes: time image is seconds, minutes, hours, date (bcd bytes)
package rtc_flags_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    byte_t date;
    byte_t hours;
    byte_t minutes;
    byte_t seconds;
  } time_s;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_READ,
    BUS_WRITE
  } bus_state_e;
endpackage

/* File: core/rtc_time_if.sv */
// Purpose: time image carrier between the flag core and its helpers
// Assumes: single clock
// Notes: none
interface rtc_time_if;
  rtc_flags_pkg::time_s now;
  rtc_flags_pkg::time_s alarm;
  logic [3:0] alarm_mask;
  logic match;
  modport cmp (input now, input alarm, input alarm_mask, output match);
  modport core (output now, output alarm, output alarm_mask, input match);
endinterface

/* File: core/rtc_alarm_cmp.sv */
// Purpose: alarm comparator on unmasked fields
// Assumes: fields are bcd bytes
// Notes: a mask bit of 1 drops its field from the match
module rtc_alarm_cmp (
  rtc_time_if.cmp t
);
  function automatic logic field_ok(input logic m, input logic [7:0] a,
                                    input logic [7:0] b);
    field_ok = m | (a == b);
  endfunction
  always_comb begin
    t.match = field_ok(t.alarm_mask[0], t.alarm.seconds, t.now.seconds) & // R13
              field_ok(t.alarm_mask[1], t.alarm.minutes, t.now.minutes) &
              field_ok(t.alarm_mask[2], t.alarm.hours, t.now.hours) &
              field_ok(t.alarm_mask[3], t.alarm.date, t.now.date); // R2
  end
endmodule

/* File: core/rtc_sq_wave.sv */
// Purpose: 512 Hz calibration square wave
// Assumes: 100 MHz i_ref_clk
// Notes: held low and counter cleared while disabled
`include "rtc_flags_defines.svh"
module rtc_sq_wave (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_en,
  output logic o_wave
);
  localparam int HALF = `SQ_HALF_CYC;
  logic [16:0] cnt_reg, cnt_next;
  logic wave_reg, wave_next;
  always_comb begin
    cnt_next = cnt_reg;
    wave_next = wave_reg;
    if (!i_en) begin
      cnt_next = 17'h0;
      wave_next = 1'b0;
    end else if (cnt_reg == 17'(HALF - 1)) begin
      cnt_next = 17'h0;
      wave_next = ~wave_reg; // R7
    end else begin
      cnt_next = cnt_reg + 17'h1;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 17'h0;
      wave_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      wave_reg <= wave_next;
    end
  end
  assign o_wave = wave_reg;
endmodule

/* File: sim/rtc_host_model.sv */
// Purpose: host processor on the async memory bus
// Assumes: write strobes held 4 cycles and read strobes 6, both more than the core needs
// Notes: released data pins show the inverse of the last write
module rtc_host_model (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_bus,
  input wire logic i_drv,
  output logic [16:0] o_addr,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [7:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_addr = 17'h0;
    o_ce_n = 1'b1;
    o_we_n = 1'b1;
    o_oe_n = 1'b1;
    o_dq = 8'h5a;
  end
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_dq <= d;
    o_ce_n <= 1'b0;
    o_we_n <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    o_ce_n <= 1'b1;
    o_we_n <= 1'b1;
    @(posedge i_ref_clk);
    // no pull on the data pins, so never leave the old value standing
    o_dq <= ~d;
    repeat (4) @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [16:0] a, output logic [7:0] d,
                    output logic drv);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_ce_n <= 1'b0;
    o_oe_n <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    d = i_bus;
    drv = i_drv;
    o_ce_n <= 1'b1;
    o_oe_n <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
  endtask
endmodule

/* File: sim/rtc_flags_status_register_bench.sv */
// Purpose: self-checking bench for the rtc flags register
// Assumes: host model on the memory bus, 100 MHz clock
// Notes: osc-fail set needs 5 ms of idle oscillator, not run here
module rtc_flags_status_register_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [16:0] FA = 17'h1fff0;
  localparam logic [31:0] TV = 32'h15234530;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_por_n = 1'b0;
  logic i_wdog_expire = 1'b0;
  logic i_supply_low = 1'b0;
  logic i_osc_running = 1'b1;
  logic i_tick = 1'b0;
  logic i_int_level = 1'b0;
  logic [31:0] i_user_time = TV;
  // out-of-range time fields, so no match before the alarm test
  logic [31:0] i_alarm_time = 32'h99999999;
  logic [3:0] i_alarm_mask = 4'h0;
  logic [16:0] i_addr;
  logic i_ce_n, i_we_n, i_oe_n, o_dq_oe, o_int, rd_oe;
  logic o_time_frozen, o_time_load, o_read_hold;
  logic [7:0] host_dq, o_dq, rd_d;
  logic [31:0] o_count_time, o_visible_time;
  wire [7:0] i_dq = o_dq_oe ? o_dq : host_dq;
  int fail_count = 0;
  int checks = 0;
  logic [15:0] rows [6] = '{16'hff07, 16'h0404, 16'h0202, 16'h0101,
                            16'h0800, 16'h0000};
  always #5 i_ref_clk = ~i_ref_clk;
  rtc_flags_reg rtc_flags_reg_inst (.i_ref_clk, .i_resetn, .i_por_n,
    .i_addr, .i_ce_n, .i_we_n, .i_oe_n, .i_dq, .o_dq, .o_dq_oe,
    .i_wdog_expire, .i_supply_low, .i_osc_running, .i_tick,
    .i_user_time, .i_alarm_time, .i_alarm_mask, .i_int_level, .o_int,
    .o_time_frozen, .o_time_load, .o_read_hold, .o_count_time,
    .o_visible_time);
  rtc_host_model rtc_host_model_inst (.i_ref_clk, .i_bus(i_dq),
    .i_drv(o_dq_oe), .o_addr(i_addr), .o_ce_n(i_ce_n), .o_we_n(i_we_n),
    .o_oe_n(i_oe_n), .o_dq(host_dq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] exp);
    rtc_host_model_inst.rd(FA, rd_d, rd_oe);
    check({24'h0, rd_d}, {24'h0, exp});
    check({31'h0, rd_oe}, 32'h1);
  endtask
  task automatic wr(input logic [7:0] d);
    rtc_host_model_inst.wr(FA, d);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    i_por_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    wr(8'h00);
    rdchk(8'h00);
    for (int n = 0; n < 6; n++) begin
      wr(rows[n][15:8]);
      rdchk(rows[n][7:0]);
      check({31'h0, o_time_frozen}, {31'h0, rows[n][1]});
      check({31'h0, o_read_hold}, {31'h0, rows[n][0]});
    end
    i_wdog_expire <= 1'b1;
    i_supply_low <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_wdog_expire <= 1'b0;
    i_supply_low <= 1'b0;
    rdchk(8'ha0);
    rdchk(8'h00);
    // unmapped place: no drive, no effect
    rtc_host_model_inst.wr(17'h1fff1, 8'h07);
    rtc_host_model_inst.rd(17'h1fff1, rd_d, rd_oe);
    check({31'h0, rd_oe}, 32'h0);
    rdchk(8'h00);
    wr(8'h02);
    wr(8'h00);
    check(o_count_time, TV);
    wr(8'h02);
    i_user_time <= 32'h01020304;
    repeat (3) begin
      @(posedge i_ref_clk);
      i_tick <= 1'b1;
      @(posedge i_ref_clk);
      i_tick <= 1'b0;
    end
    check(o_visible_time, TV);
    i_user_time <= TV;
    wr(8'h01);
    check(o_count_time, TV);
    @(posedge i_ref_clk);
    i_tick <= 1'b1;
    @(posedge i_ref_clk);
    i_tick <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    check(o_visible_time, TV);
    wr(8'h02);
    wr(8'h00);
    i_alarm_time <= 32'h15234531;
    rdchk(8'h00);
    i_alarm_mask <= 4'h1;
    rdchk(8'h40);
    i_alarm_time <= 32'h99999999;
    rdchk(8'h00);
    rdchk(8'h00);
    i_int_level <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    check({31'h0, o_int}, 32'h1);
    // wave starts low and its half period is far longer than this
    wr(8'h04);
    check({31'h0, o_int}, 32'h0);
    wr(8'h00);
    check({31'h0, o_int}, 32'h1);
    wr(8'h07);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    rdchk(8'h00);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    fail_count++;
    finish_test();
  end
endmodule
